// File: core/sidx_exec.sv
// Purpose: hold one interrupt transfer descriptor and run its start/complete split transactions
// Assumes: link engine on the same clock answers every request with one done pulse
// Notes: data payload lives elsewhere; only its address and length are handed out
//
// Our own choices: the placing of the registers and the address-and-strobe port.

`timescale 1ns/1ps

module sidx_exec
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [sidx_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_uframe_tick,
   input wire logic i_txn_done,
   input wire sidx_pkg::sidx_res_t i_txn_result,
   input wire logic [10:0] i_txn_bytes,
   output logic o_txn_req,
   output sidx_pkg::sidx_txn_t o_txn,
   output logic o_retired,
   output logic o_fatal
);
   import sidx_pkg::*;

   logic [31:0] dw_ff [DW_COUNT];
   sidx_fields_t fld;
   logic [7:0] period_mask;
   sidx_state_t state_ff;
   sidx_state_t nxt_state;
   logic [7:0] uf_cnt_ff;
   logic txn_req_ff;
   sidx_txn_t txn_ff;
   sidx_txn_t nxt_txn;
   logic [31:0] rdata_ff;
   logic retired_ff;
   logic fatal_ff;
   logic addr_hit;
   logic [1:0] widx;
   logic due;
   logic can_start;
   logic start;
   logic done;
   logic [12:0] new_xferred;
   logic [14:0] total_eff;
   logic [14:0] remaining;
   logic all_done;
   logic [31:0] hw_dw3;
   logic hw_clr_valid;
   logic retire;
   logic fatal;

   sidx_decode u_dec
   (
      .i_dw0(dw_ff[0]),
      .i_dw1(dw_ff[1]),
      .i_dw2(dw_ff[2]),
      .i_dw3(dw_ff[3]),
      .o_fld(fld),
      .o_period_mask(period_mask)
   );

   // address decode: aligned words only, anything else is unmapped
   assign addr_hit = (i_addr >= OFF_DW0) && (i_addr <= OFF_DW3) && (i_addr[1:0] == 2'h0);
   assign widx = i_addr[3:2];

   // microframe counter free-runs so every period boundary lines up
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         uf_cnt_ff <= 8'h00;
      else if (i_uframe_tick)
         uf_cnt_ff <= uf_cnt_ff + 8'h01;
   end

   // due on period boundary; complete split goes next microframe
   assign due = i_uframe_tick && (fld.split_phase || ((uf_cnt_ff & period_mask) == 8'h00));

   // only a valid interrupt descriptor with a known token may start
   assign can_start = fld.valid && (fld.transfer_kind == KIND_INTR)
                      && ((fld.token == TOKEN_OUT) || (fld.token == TOKEN_IN));
   assign start = (state_ff == ST_IDLE) && can_start && due;
   assign done = (state_ff == ST_WAIT) && i_txn_done;

   // total capped at 4 kB; remaining sizes the next packet
   always_comb
   begin
      total_eff = (fld.xfer_byte_count > MAX_TOTAL) ? MAX_TOTAL : fld.xfer_byte_count;
      remaining = (total_eff > {3'h0, fld.xferred}) ? (total_eff - {3'h0, fld.xferred}) : 15'h0000;
      new_xferred = {1'b0, fld.xferred} + {2'h0, i_txn_bytes};
      // a short packet also ends the transfer
      all_done = ({2'h0, new_xferred} >= total_eff) || (i_txn_bytes < txn_ff.len);
   end

   // build the request from the decoded descriptor
   always_comb
   begin
      // split flag chooses the transaction form
      nxt_txn.split = fld.split;
      nxt_txn.phase = fld.split & fld.split_phase;
      // token code passed as out or in
      nxt_txn.token = fld.token;
      nxt_txn.func_addr = fld.function_addr;
      nxt_txn.endpoint_num = fld.endpoint_num;
      // speed code only meaningful for split
      nxt_txn.speed = fld.split ? fld.split_speed_code : SPEED_FULL;
      nxt_txn.hub_addr = fld.hub_addr;
      nxt_txn.hub_port = fld.hub_port;
      nxt_txn.toggle = fld.toggle;
      nxt_txn.data_addr = fld.data_addr;
      // packet bounded by max length and by 64 on split targets
      nxt_txn.len = fld.max_pkt_len;
      if (fld.split && (nxt_txn.len > MAX_FS_PKT))
         nxt_txn.len = MAX_FS_PKT;
      if ({4'h0, nxt_txn.len} > remaining)
         nxt_txn.len = remaining[10:0];
   end

   // outcome of a finished transaction, written back into dw3 and valid
   always_comb
   begin
      hw_dw3 = dw_ff[3];
      hw_clr_valid = 1'b0;
      retire = 1'b0;
      fatal = 1'b0;
      if (done)
      begin
         case (i_txn_result)
            RES_ACK:
            begin
               // start split acknowledged, move to complete split
               if (fld.split && !fld.split_phase)
                  hw_dw3[PHASE_BIT] = 1'b1;
               else
               begin
                  hw_dw3[XFERRED_LO +: 12] = new_xferred[11:0];
                  hw_dw3[DT_BIT] = ~fld.toggle;
                  hw_dw3[PHASE_BIT] = 1'b0;
                  if (all_done)
                  begin
                     hw_clr_valid = 1'b1;
                     retire = 1'b1;
                  end
               end
            end
            RES_NYET: hw_dw3 = dw_ff[3]; // hub not ready, repeat complete split
            RES_NAK: hw_dw3[PHASE_BIT] = 1'b0; // retry from start split at next period
            RES_STALL:
            begin
               hw_dw3[HALT_BIT] = 1'b1;
               hw_clr_valid = 1'b1;
               retire = 1'b1;
               fatal = 1'b1;
            end
            RES_BABBLE:
            begin
               hw_dw3[BABBLE_BIT] = 1'b1;
               hw_dw3[HALT_BIT] = 1'b1;
               hw_clr_valid = 1'b1;
               retire = 1'b1;
               fatal = 1'b1;
            end
            default:
            begin
               hw_dw3[XERR_BIT] = 1'b1;
               // retry while the counter lasts, halt at zero
               if (fld.cerr == 2'h0)
               begin
                  hw_dw3[HALT_BIT] = 1'b1;
                  hw_clr_valid = 1'b1;
                  retire = 1'b1;
                  fatal = 1'b1;
               end
               else
                  hw_dw3[CERR_LO +: 2] = fld.cerr - 2'h1;
            end
         endcase
      end
   end

   // descriptor store: software writes, then hardware write-back
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < DW_COUNT; i++)
            dw_ff[i] <= DW_RESET;
      end
      else
      begin
         // reserved bits keep their value on writes
         if (i_wr && addr_hit)
            dw_ff[widx] <= (i_wdata & WMASK[widx]) | (dw_ff[widx] & ~WMASK[widx]);
         // hardware owns the status word while it writes back
         if (done)
            dw_ff[3] <= hw_dw3;
         // clear valid; a software set in the same cycle wins
         if (hw_clr_valid && !(i_wr && addr_hit && (widx == 2'h0) && i_wdata[V_BIT]))
            dw_ff[0][V_BIT] <= 1'b0;
      end
   end

   // state and request: request stays up until the link reports done
   always_comb
   begin
      case (state_ff)
         ST_IDLE: nxt_state = start ? ST_WAIT : ST_IDLE;
         ST_WAIT: nxt_state = i_txn_done ? ST_IDLE : ST_WAIT;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // request flag and its payload, frozen for the whole transaction
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         txn_req_ff <= 1'b0;
         txn_ff <= '0;
      end
      else if (start)
      begin
         txn_req_ff <= 1'b1;
         txn_ff <= nxt_txn;
      end
      else if (done)
         txn_req_ff <= 1'b0;
   end

   // retirement pulses, one cycle after the done answer, on the same edge as the write-back
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         retired_ff <= 1'b0;
         fatal_ff <= 1'b0;
      end
      else
      begin
         retired_ff <= retire;
         fatal_ff <= fatal;
      end
   end

   // read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         rdata_ff <= 32'h0000_0000;
      else if (i_rd && addr_hit)
         rdata_ff <= dw_ff[widx];
      else
         rdata_ff <= 32'h0000_0000;
   end

   assign o_rdata = rdata_ff;
   assign o_txn_req = txn_req_ff;
   assign o_txn = txn_ff;
   assign o_retired = retired_ff;
   assign o_fatal = fatal_ff;

endmodule : sidx_exec

// File: include/sidx_pkg.sv
// Purpose: shared constants and types for the split interrupt descriptor executor
// Assumes: descriptor of four 32-bit words held in flip-flops, word n at byte offset 4*n
// Notes: bit positions inside dw1 and dw3 are given relative to that word

package sidx_pkg;

   // register port geometry and word offsets
   localparam int ADDR_W = 8;
   localparam int DW_COUNT = 4;
   localparam logic [7:0] OFF_DW0 = 8'h00;
   localparam logic [7:0] OFF_DW3 = 8'h0c;

   // dw0 fields
   localparam int V_BIT = 0;
   localparam int XFER_CNT_LO = 3;
   localparam int MPL_LO = 18;
   localparam int EP0_BIT = 31;
   // dw1 fields
   localparam int EPHI_LO = 0;
   localparam int FADDR_LO = 3;
   localparam int TOKEN_LO = 10;
   localparam int KIND_LO = 12;
   localparam int SPLIT_BIT = 14;
   localparam int SPEED_LO = 16;
   localparam int PORT_LO = 18;
   localparam int HUB_LO = 25;
   // dw2 fields
   localparam int POLL_LO = 3;
   localparam int DSA_LO = 8;
   // dw3 fields
   localparam int XFERRED_LO = 0;
   localparam int CERR_LO = 23;
   localparam int DT_BIT = 25;
   localparam int PHASE_BIT = 27;
   localparam int XERR_BIT = 28;
   localparam int BABBLE_BIT = 29;
   localparam int HALT_BIT = 30;

   // writable bits per word; reserved bits keep their value
   localparam logic [31:0] WMASK [DW_COUNT] = '{32'h9fff_fff9, 32'hffff_7fff, 32'h00ff_ffff, 32'hfb80_0fff};
   localparam logic [31:0] DW_RESET = 32'h0000_0000;

   // field encodings
   localparam logic [1:0] KIND_INTR = 2'h3;
   localparam logic [1:0] TOKEN_OUT = 2'h0;
   localparam logic [1:0] TOKEN_IN = 2'h1;
   localparam logic [1:0] SPEED_LOW = 2'h2;
   localparam logic [1:0] SPEED_FULL = 2'h0;
   localparam logic [10:0] MAX_FS_PKT = 11'h040;
   localparam logic [14:0] MAX_TOTAL = 15'h1000;

   // polling: masks of the microframe counter for periods of 1,2,4,8,16,32 ms
   localparam logic [7:0] PMASK_1MS = 8'h07;
   localparam logic [7:0] PMASK_2MS = 8'h0f;
   localparam logic [7:0] PMASK_4MS = 8'h1f;
   localparam logic [7:0] PMASK_8MS = 8'h3f;
   localparam logic [7:0] PMASK_16MS = 8'h7f;
   localparam logic [7:0] PMASK_32MS = 8'hff;

   typedef enum logic [2:0] {
      RES_ACK = 3'h0,
      RES_NAK = 3'h1,
      RES_NYET = 3'h2,
      RES_STALL = 3'h3,
      RES_ERR = 3'h4,
      RES_BABBLE = 3'h5
   } sidx_res_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01
   } sidx_state_t;

   // one transaction handed to the link engine
   typedef struct packed {
      logic split;
      logic phase;
      logic [1:0] token;
      logic [6:0] func_addr;
      logic [3:0] endpoint_num;
      logic [1:0] speed;
      logic [6:0] hub_addr;
      logic [6:0] hub_port;
      logic toggle;
      logic [10:0] len;
      logic [15:0] data_addr;
   } sidx_txn_t;

   // decoded descriptor
   typedef struct packed {
      logic valid;
      logic [14:0] xfer_byte_count;
      logic [10:0] max_pkt_len;
      logic [3:0] endpoint_num;
      logic [6:0] function_addr;
      logic [1:0] token;
      logic [1:0] transfer_kind;
      logic split;
      logic [1:0] split_speed_code;
      logic [6:0] hub_port;
      logic [6:0] hub_addr;
      logic [4:0] poll;
      logic [15:0] data_addr;
      logic [11:0] xferred;
      logic [1:0] cerr;
      logic toggle;
      logic split_phase;
   } sidx_fields_t;

endpackage : sidx_pkg

// File: core/sidx_decode.sv
// Purpose: split the stored descriptor words into named fields and a polling mask
// Assumes: words arrive straight from the descriptor flip-flops
// Notes: purely combinational

`timescale 1ns/1ps

module sidx_decode
(
   input wire logic [31:0] i_dw0,
   input wire logic [31:0] i_dw1,
   input wire logic [31:0] i_dw2,
   input wire logic [31:0] i_dw3,
   output sidx_pkg::sidx_fields_t o_fld,
   output logic [7:0] o_period_mask
);
   import sidx_pkg::*;

   always_comb
   begin
      o_fld.valid = i_dw0[V_BIT];
      o_fld.xfer_byte_count = i_dw0[XFER_CNT_LO +: 15];
      o_fld.max_pkt_len = i_dw0[MPL_LO +: 11];
      o_fld.endpoint_num = {i_dw1[EPHI_LO +: 3], i_dw0[EP0_BIT]};
      o_fld.function_addr = i_dw1[FADDR_LO +: 7];
      o_fld.token = i_dw1[TOKEN_LO +: 2];
      o_fld.transfer_kind = i_dw1[KIND_LO +: 2];
      o_fld.split = i_dw1[SPLIT_BIT];
      o_fld.split_speed_code = i_dw1[SPEED_LO +: 2];
      o_fld.hub_port = i_dw1[PORT_LO +: 7];
      o_fld.hub_addr = i_dw1[HUB_LO +: 7];
      o_fld.poll = i_dw2[POLL_LO +: 5];
      o_fld.data_addr = i_dw2[DSA_LO +: 16];
      o_fld.xferred = i_dw3[XFERRED_LO +: 12];
      o_fld.cerr = i_dw3[CERR_LO +: 2];
      o_fld.toggle = i_dw3[DT_BIT];
      o_fld.split_phase = i_dw3[PHASE_BIT];
   end

   // highest set poll bit picks period
   always_comb
   begin
      if (o_fld.poll[4])
         o_period_mask = PMASK_32MS;
      else if (o_fld.poll[3])
         o_period_mask = PMASK_16MS;
      else if (o_fld.poll[2])
         o_period_mask = PMASK_8MS;
      else if (o_fld.poll[1])
         o_period_mask = PMASK_4MS;
      else if (o_fld.poll[0])
         o_period_mask = PMASK_2MS;
      else
         o_period_mask = PMASK_1MS;
   end

endmodule : sidx_decode

// File: tb/sidx_link_model.sv
// Purpose: link engine stand-in that answers each transaction request
// Assumes: same clock as the executor, one request outstanding
// Notes: result, byte cap and answer delay are set by the bench
`timescale 1ns/1ps
module sidx_link_model
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire sidx_pkg::sidx_txn_t i_txn,
   input wire sidx_pkg::sidx_res_t i_res,
   input wire logic [10:0] i_cap,
   input wire logic [3:0] i_wait,
   output logic o_done,
   output sidx_pkg::sidx_res_t o_res,
   output logic [10:0] o_bytes
);
   import sidx_pkg::*;
   logic [3:0] cnt_ff;
   logic busy;
   // a request is pending until our done pulse has been seen
   assign busy = i_req && !o_done;
   // answer i_wait+1 cycles after the request rises; idle lines keep changing so stale values are never trusted
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_done <= 1'b0;
         o_res <= RES_ACK;
         o_bytes <= 11'h000;
         cnt_ff <= 4'h0;
      end
      else
      begin
         o_done <= busy && cnt_ff == i_wait;
         cnt_ff <= (busy && cnt_ff != i_wait) ? cnt_ff + 4'h1 : 4'h0;
         o_res <= busy ? i_res : sidx_res_t'(~o_res);
         o_bytes <= busy ? ((i_cap < i_txn.len) ? i_cap : i_txn.len) : ~o_bytes;
      end
   end
endmodule : sidx_link_model

// File: tb/sidx_exec_asserts.sv
// Purpose: port-level checks for the split interrupt descriptor executor
// Assumes: one clock, asynchronous active-high reset
// Notes: bound onto every executor instance
`timescale 1ns/1ps
module sidx_exec_chk
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [sidx_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic i_uframe_tick,
   input wire logic i_txn_done,
   input wire sidx_pkg::sidx_res_t i_txn_result,
   input wire logic [10:0] i_txn_bytes,
   input wire logic o_txn_req,
   input wire sidx_pkg::sidx_txn_t o_txn,
   input wire logic o_retired,
   input wire logic o_fatal
);
   import sidx_pkg::*;
   default clocking dcb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   // request answered by the link
   sequence s_done;
      o_txn_req && i_txn_done;
   endsequence
   // request dropped beside a fatal retirement, then the pulse ends
   sequence s_fatal_end;
      (!o_txn_req && o_retired && o_fatal) ##1 !o_retired;
   endsequence
   property p_req_tick;
      $rose(o_txn_req) |-> $past(i_uframe_tick);
   endproperty
   property p_tok;
      o_txn_req |-> (o_txn.token == TOKEN_OUT || o_txn.token == TOKEN_IN);
   endproperty
   property p_len;
      o_txn_req && o_txn.split |-> o_txn.len <= MAX_FS_PKT;
   endproperty
   property p_hold;
      o_txn_req && !i_txn_done |=> o_txn_req && $stable(o_txn);
   endproperty
   property p_fatal;
      s_done ##0 (i_txn_result == RES_STALL || i_txn_result == RES_BABBLE) |=> s_fatal_end;
   endproperty
   property p_pulse;
      o_retired |=> !o_retired;
   endproperty
   property p_fat_ret;
      o_fatal |-> o_retired;
   endproperty
   property p_split_ack;
      s_done ##0 (o_txn.split && !o_txn.phase && i_txn_result == RES_ACK) |=> !o_retired;
   endproperty
   property p_nyet;
      s_done ##0 (i_txn_result == RES_NYET) |=> !o_retired;
   endproperty
   property p_cause;
      o_retired |-> $past(i_txn_done);
   endproperty
   a_req_tick: assert property (p_req_tick) else $error("request without tick");
   a_tok: assert property (p_tok) else $error("bad token issued");
   a_len: assert property (p_len) else $error("split packet too long");
   a_hold: assert property (p_hold) else $error("request changed while pending");
   a_fatal: assert property (p_fatal) else $error("fatal result not retired");
   a_pulse: assert property (p_pulse) else $error("retire longer than one cycle");
   a_fat_ret: assert property (p_fat_ret) else $error("fatal without retire");
   a_split_ack: assert property (p_split_ack) else $error("start split retired");
   a_nyet: assert property (p_nyet) else $error("not yet answer retired");
   a_cause: assert property (p_cause) else $error("retire without answer");
endmodule : sidx_exec_chk
bind sidx_exec sidx_exec_chk i_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_uframe_tick(i_uframe_tick), .i_txn_done(i_txn_done),
   .i_txn_result(i_txn_result), .i_txn_bytes(i_txn_bytes), .o_txn_req(o_txn_req), .o_txn(o_txn),
   .o_retired(o_retired), .o_fatal(o_fatal));

// File: tb/testbench.sv
// Purpose: directed bench for the split interrupt descriptor executor
// Assumes: link model answers every request; descriptor written with valid last
// Notes: each tick leaves 12 cycles for answer and retirement to settle
`timescale 1ns/1ps
module testbench;
   import sidx_pkg::*;
   logic i_mclk, i_rst, i_wr, i_rd, tick, got, done, req, ret, fat;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [10:0] bytes, cap;
   logic [3:0] wt;
   sidx_res_t res, lres;
   sidx_txn_t txn, txs, e;
   int mismatches, n_compared, nt, nret, nfat, i;
   logic [31:0] a0 = {1'b1, 2'b0, 11'd8, 15'd8, 3'b001};
   logic [31:0] a1 = {18'h0, 2'b11, 2'b00, 7'h5a, 3'b101};
   logic [31:0] a3 = {7'h0, 2'b11, 23'h0};
   logic [31:0] b0 = {3'b0, 11'd100, 15'd200, 3'b001};
   logic [31:0] b1 = {7'h11, 7'h03, 2'b10, 2'b01, 2'b11, 2'b01, 7'h22, 3'b010};
   logic [4:0] pv [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f};
   sidx_exec i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(rdata), .i_uframe_tick(tick), .i_txn_done(done), .i_txn_result(lres), .i_txn_bytes(bytes),
      .o_txn_req(req), .o_txn(txn), .o_retired(ret), .o_fatal(fat));
   sidx_link_model i_link (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req), .i_txn(txn), .i_res(res), .i_cap(cap),
      .i_wait(wt), .o_done(done), .o_res(lres), .o_bytes(bytes));
   // 100 MHz clock
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   // run needs about 15k cycles; 80k means a hang
   initial
   begin
      #800000;
      mismatches++;
      end_sim();
   end
   // count retirement pulses
   always @(posedge i_mclk)
   begin
      if (ret === 1'b1)
         nret++;
      if (fat === 1'b1)
         nfat++;
   end
   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      addr <= a;
      wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge i_mclk);
      addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk("rdata", rdata, x);
   endtask : rd
   task desc(input logic [31:0] d0, input logic [31:0] d1, input logic [31:0] d2, input logic [31:0] d3);
      wr(8'h04, d1);
      wr(8'h08, d2);
      wr(OFF_DW3, d3);
      wr(OFF_DW0, d0);
   endtask : desc
   // one microframe tick; snapshot any request it starts
   task tk;
      @(posedge i_mclk);
      tick <= 1'b1;
      @(posedge i_mclk);
      tick <= 1'b0;
      nt++;
      #1;
      if (req === 1'b1)
      begin
         got = 1'b1;
         txs = txn;
      end
      repeat (12) @(posedge i_mclk);
   endtask : tk
   task go(input int n);
      got = 1'b0;
      nt = 0;
      nret = 0;
      nfat = 0;
      while (got !== 1'b1 && nt < n)
         tk();
   endtask : go
   task outc(input int g, input int r, input int f);
      chk("req", got, g);
      chk("retired", nret, r);
      chk("fatal", nfat, f);
   endtask : outc
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   // main sequence
   initial
   begin
      i_rst = 1'b1;
      {i_wr, i_rd, tick, got, addr, wdata, wt, nret, nfat, mismatches, n_compared} = '0;
      res = RES_ACK;
      cap = 11'h7ff;
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      for (i = 0; i < 4; i++)
         rd(8'(i * 4), DW_RESET);
      for (i = 0; i < 4; i++)
         wr(8'(i * 4), 32'hffff_ffff);
      for (i = 0; i < 4; i++)
         rd(8'(i * 4), WMASK[i]);
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10, 32'h0);
      rd(8'h02, 32'h0);
      desc(a0 & ~32'h1, a1, 32'h0012_3400, a3);
      go(10);
      outc(0, 0, 0);
      desc(a0, a1 | 32'h0800, 32'h0012_3400, a3);
      go(10);
      outc(0, 0, 0);
      desc(a0, a1 & ~32'h1000, 32'h0012_3400, a3);
      go(10);
      outc(0, 0, 0);
      wt = 4'h3;
      desc(a0, a1, 32'h0012_3400, a3);
      go(10);
      e = '0;
      e.func_addr = 7'h5a;
      e.endpoint_num = 4'hb;
      e.len = 11'd8;
      e.data_addr = 16'h1234;
      chk("txn", txs, e);
      outc(1, 1, 0);
      rd(OFF_DW0, a0 & ~32'h1);
      rd(OFF_DW3, {6'h0, 1'b1, 2'b11, 23'd8});
      // a short packet ends the transfer early
      cap = 11'h004;
      desc(a0, a1, 32'h0012_3400, a3);
      go(10);
      outc(1, 1, 0);
      rd(OFF_DW3, {6'h0, 1'b1, 2'b11, 23'd4});
      cap = 11'h7ff;
      wt = 4'h0;
      desc(b0, b1, 32'h0004_0000, a3);
      go(10);
      e = '{split: 1'b1, token: TOKEN_IN, func_addr: 7'h22, endpoint_num: 4'h4, speed: SPEED_LOW,
         hub_addr: 7'h11, hub_port: 7'h03, len: MAX_FS_PKT, data_addr: 16'h0400, default: '0};
      chk("txn", txs, e);
      outc(1, 0, 0);
      res = RES_NYET;
      e.phase = 1'b1;
      go(1);
      chk("txn", txs, e);
      outc(1, 0, 0);
      res = RES_ACK;
      go(1);
      chk("txn", txs, e);
      rd(OFF_DW3, {6'h0, 1'b1, 2'b11, 23'd64});
      res = RES_ERR;
      e.phase = 1'b0;
      e.toggle = 1'b1;
      go(10);
      chk("txn", txs, e);
      outc(1, 0, 0);
      rd(OFF_DW3, {3'h0, 1'b1, 2'b00, 1'b1, 2'b10, 23'd64});
      res = RES_STALL;
      go(10);
      outc(1, 1, 1);
      rd(OFF_DW3, {3'h2, 1'b1, 2'b00, 1'b1, 2'b10, 23'd64});
      rd(OFF_DW0, b0 & ~32'h1);
      res = RES_ERR;
      desc(a0, a1, 32'h0012_3400, 32'h0);
      go(10);
      outc(1, 1, 1);
      rd(OFF_DW3, 32'h5000_0000);
      res = RES_BABBLE;
      desc(a0, a1, 32'h0012_3400, 32'h0);
      go(10);
      outc(1, 1, 1);
      rd(OFF_DW3, 32'h6000_0000);
      // a refused answer keeps the descriptor, so starts repeat at the period
      res = RES_NAK;
      for (i = 0; i < 6; i++)
      begin
         desc(a0, a1, {8'h0, 16'h1234, pv[i], 3'h0}, a3);
         go(300);
         go(300);
         chk("period", nt, 8 << i);
      end
      end_sim();
   end
endmodule : testbench
